// ### logic/pd_soft_reset_regs.svh
// timing constants and message codes for the link restart engine
// Notes on behaviour
// - entering own-caps reply: fetch local capabilities, then send them
// - own-caps message sent successfully returns to consumer idle contract
// - policy request for partner offer: send query, back to idle when sent
// - non-interruptible protocol error or retries exhausted: start link restart
// - provider offer fails without ack while unattached: go to attach search
// - failure while voltage moves to new contract: full reset instead
// - power swap supply transition failure: provider recovery, consumer full reset
// - data swap: provider role field mismatch, consumer role change: recovery
// - interruptible sequence error: go idle, handle message there, no restart
// - unexpected message before first send: go idle and handle it normally
// - start link restart: reset protocol layer, send restart, start response timer
// - accept in start state: provider to offer sending, consumer to wait offer
// - consumer start state: timer expiry or send error gives full reset
// - restart message received anywhere: answer state, reset protocol, send accept
// - accept answer sent: provider to offer sending, consumer to wait offer
// - send error in either restart state gives full reset
// - unknown or unsupported message in idle is answered with a not-supported message
`ifndef PD_SOFT_RESET_REGS_SVH
`define PD_SOFT_RESET_REGS_SVH
`define SENDER_RSP_US 30
`define CLK_MHZ 200
`define MSG_SINK_CAPS 4'h4
`define MSG_GET_SRC_CAP 4'h7
`define MSG_GET_SINK_CAP 4'h8
`define MSG_SOFT_RESET 4'hD
`define MSG_ACCEPT 4'h3
`define MSG_NOT_SUPP 4'h0
`endif

// ### logic/pd_soft_reset_pkg.sv
// types for the link restart engine
package pd_soft_reset_pkg;
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_OWN_CAPS_FETCH = 11'h002,
    ST_OWN_CAPS_SEND = 11'h004,
    ST_QUERY_OFFER = 11'h008,
    ST_START_RESET = 11'h010,
    ST_START_SEND = 11'h020,
    ST_ANSWER_RESET = 11'h040,
    ST_ANSWER_SEND = 11'h080,
    ST_NOT_SUPP = 11'h100,
    ST_EXIT = 11'h200,
    ST_HOLD = 11'h400
  } pe_state_t;
  typedef enum logic [5:0] {
    EX_NONE = 6'h01,
    EX_OFFER_SENDING = 6'h02,
    EX_WAIT_OFFER = 6'h04,
    EX_FULL_RESET = 6'h08,
    EX_ATTACH_SEARCH = 6'h10,
    EX_ERROR_RECOVERY = 6'h20
  } pe_exit_t;
  typedef struct packed {
    logic valid;
    logic [3:0] msg_type;
  } pd_msg_t;
  typedef struct packed {
    logic noninterruptible;
    logic first_sent;
    logic in_offer_sending;
    logic attached;
    logic contract_transition;
    logic pr_swap_transition;
    logic dr_swap_field_mismatch;
    logic dr_swap_roles_changing;
  } pd_context_t;
endpackage

// ### logic/pd_response_timer.sv
// one-shot sender response timer
`timescale 1ns/1ps
`default_nettype none
module pd_response_timer #(
  parameter int unsigned CYCLES = 6000
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_stop,
  output logic o_expired
);
  logic [15:0] count_q;
  logic run_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_stop) begin
      run_q <= 1'b0;
      count_q <= 16'h0000;
      o_expired <= 1'b0;
    end else if (i_start) begin
      run_q <= 1'b1;
      count_q <= 16'(CYCLES - 1);
      o_expired <= 1'b0;
    end else if (run_q) begin
      if (count_q == 16'h0000) begin
        run_q <= 1'b0;
        o_expired <= 1'b1;
      end else begin
        count_q <= count_q - 16'h0001;
      end
    end else begin
      o_expired <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### logic/pd_tx_request.sv
// registered transmit request toward the protocol layer
`timescale 1ns/1ps
`default_nettype none
module pd_tx_request
  import pd_soft_reset_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_load,
  input wire logic [3:0] i_msg_type,
  output pd_msg_t o_tx
);
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_tx <= '0;
    end else begin
      o_tx.valid <= i_load;
      o_tx.msg_type <= i_load ? i_msg_type : o_tx.msg_type;
    end
  end
endmodule
`default_nettype wire

// ### logic/pd_soft_reset_engine.sv
// policy engine: consumer requests, link restart and protocol errors
`include "pd_soft_reset_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pd_soft_reset_engine
  import pd_soft_reset_pkg::*;
#(
  parameter bit IS_PROVIDER = 1'b0,
  parameter int unsigned RSP_CYCLES = `SENDER_RSP_US * `CLK_MHZ
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire pd_msg_t i_rx,
  input wire logic i_rx_unsupported,
  input wire logic i_tx_done,
  input wire logic i_tx_error,
  input wire logic i_protocol_error,
  input wire logic i_retries_failed,
  input wire logic i_send_caps_no_ack,
  input wire pd_context_t i_ctx,
  input wire logic i_policy_query_offer,
  input wire logic i_policy_caps_valid,
  input wire logic i_proto_reset_done,
  input wire logic i_exit_ack,
  output pd_msg_t o_tx,
  output logic o_policy_caps_req,
  output logic o_proto_reset_req,
  output logic o_handle_in_idle,
  output logic o_idle,
  output pe_exit_t o_exit,
  output logic o_exit_valid
);
  pe_state_t state_q;
  pe_state_t state_d;
  pe_exit_t exit_d;
  logic tx_load;
  logic [3:0] tx_type;
  logic timer_start;
  logic timer_expired;
  logic fault;
  logic err_idle;

  assign fault = i_retries_failed || (i_protocol_error
    && i_ctx.noninterruptible && i_ctx.first_sent);
  assign err_idle = i_protocol_error
    && (!i_ctx.noninterruptible || !i_ctx.first_sent);

  pd_response_timer #(.CYCLES(RSP_CYCLES)) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_start(timer_start),
    .i_stop(state_d != ST_START_SEND),
    .o_expired(timer_expired)
  );

  pd_tx_request u_tx (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_load(tx_load),
    .i_msg_type(tx_type),
    .o_tx(o_tx)
  );

  // failure routing, priority: exceptions first, then link restart
  function automatic pe_exit_t fault_exit(input pd_context_t c,
                                          input logic no_ack);
    pe_exit_t e;
    e = EX_NONE;
    if (IS_PROVIDER && c.in_offer_sending && !c.attached && no_ack) begin
      e = EX_ATTACH_SEARCH;
    end else if (c.contract_transition) begin
      e = EX_FULL_RESET;
    end else if (c.pr_swap_transition) begin
      e = IS_PROVIDER ? EX_ERROR_RECOVERY : EX_FULL_RESET;
    end else if (IS_PROVIDER ? c.dr_swap_field_mismatch
                             : c.dr_swap_roles_changing) begin
      e = EX_ERROR_RECOVERY;
    end
    return e;
  endfunction

  always_comb begin
    state_d = state_q;
    exit_d = EX_NONE;
    tx_load = 1'b0;
    tx_type = `MSG_NOT_SUPP;
    timer_start = 1'b0;
    if (i_rx.valid && i_rx.msg_type == `MSG_SOFT_RESET) begin
      state_d = ST_ANSWER_RESET;
    end else if (fault && state_q != ST_EXIT && state_q != ST_HOLD) begin
      exit_d = fault_exit(i_ctx, i_send_caps_no_ack);
      state_d = (exit_d == EX_NONE) ? ST_START_RESET : ST_EXIT;
    end else if (err_idle && state_q != ST_EXIT && state_q != ST_HOLD) begin
      state_d = ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (i_rx.valid && i_rx_unsupported) begin
            tx_load = 1'b1;
            tx_type = `MSG_NOT_SUPP;
            state_d = ST_NOT_SUPP;
          end else if (!IS_PROVIDER && i_policy_query_offer) begin
            tx_load = 1'b1;
            tx_type = `MSG_GET_SRC_CAP;
            state_d = ST_QUERY_OFFER;
          end else if (!IS_PROVIDER && i_rx.valid
                       && i_rx.msg_type == `MSG_GET_SINK_CAP) begin
            state_d = ST_OWN_CAPS_FETCH;
          end
        end
        ST_OWN_CAPS_FETCH: begin
          if (i_policy_caps_valid) begin
            tx_load = 1'b1;
            tx_type = `MSG_SINK_CAPS;
            state_d = ST_OWN_CAPS_SEND;
          end
        end
        ST_OWN_CAPS_SEND: begin
          if (i_tx_done) begin
            state_d = ST_IDLE;
          end
        end
        ST_QUERY_OFFER: begin
          if (i_tx_done) begin
            state_d = ST_IDLE;
          end
        end
        ST_NOT_SUPP: begin
          if (i_tx_done) begin
            state_d = ST_IDLE;
          end
        end
        ST_START_RESET: begin
          if (i_proto_reset_done) begin
            tx_load = 1'b1;
            tx_type = `MSG_SOFT_RESET;
            timer_start = 1'b1;
            state_d = ST_START_SEND;
          end
        end
        ST_START_SEND: begin
          if (i_tx_error || timer_expired) begin
            exit_d = EX_FULL_RESET;
            state_d = ST_EXIT;
          end else if (i_rx.valid && i_rx.msg_type == `MSG_ACCEPT) begin
            exit_d = IS_PROVIDER ? EX_OFFER_SENDING : EX_WAIT_OFFER;
            state_d = ST_EXIT;
          end
        end
        ST_ANSWER_RESET: begin
          if (i_proto_reset_done) begin
            tx_load = 1'b1;
            tx_type = `MSG_ACCEPT;
            state_d = ST_ANSWER_SEND;
          end
        end
        ST_ANSWER_SEND: begin
          if (i_tx_error) begin
            exit_d = EX_FULL_RESET;
            state_d = ST_EXIT;
          end else if (i_tx_done) begin
            exit_d = IS_PROVIDER ? EX_OFFER_SENDING : EX_WAIT_OFFER;
            state_d = ST_EXIT;
          end
        end
        ST_EXIT: begin
          state_d = ST_HOLD;
        end
        ST_HOLD: begin
          if (i_exit_ack) begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_exit <= EX_NONE;
      o_exit_valid <= 1'b0;
    end else begin
      o_exit_valid <= (state_d == ST_EXIT) && (state_q != ST_EXIT);
      if (state_d == ST_EXIT && state_q != ST_EXIT) begin
        o_exit <= exit_d;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_policy_caps_req <= 1'b0;
      o_proto_reset_req <= 1'b0;
      o_handle_in_idle <= 1'b0;
      o_idle <= 1'b1;
    end else begin
      o_policy_caps_req <= (state_d == ST_OWN_CAPS_FETCH)
        && (state_q != ST_OWN_CAPS_FETCH);
      o_proto_reset_req <= ((state_d == ST_START_RESET)
        && (state_q != ST_START_RESET)) || ((state_d == ST_ANSWER_RESET)
        && (state_q != ST_ANSWER_RESET));
      o_handle_in_idle <= err_idle && state_d == ST_IDLE;
      o_idle <= state_d == ST_IDLE;
    end
  end
endmodule
`default_nettype wire

// ### verif/pd_proto_model.sv
// protocol layer model answering transmit and reset requests
`timescale 1ns/1ps
`default_nettype none
module pd_proto_model
  import pd_soft_reset_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire pd_msg_t i_tx,
  input wire logic i_proto_reset_req,
  input wire logic i_fail,
  input wire logic [3:0] i_delay,
  output logic o_tx_done,
  output logic o_tx_error,
  output logic o_proto_reset_done
);
  logic [4:0] tx_cnt_q;
  logic [4:0] rst_cnt_q;
  // transmit outcome after a chosen delay, error only when commanded
  always_ff @(posedge i_clk_sys) begin
    o_tx_done <= 1'b0;
    o_tx_error <= 1'b0;
    if (i_srst) begin
      tx_cnt_q <= 5'h00;
    end else if (i_tx.valid) begin
      tx_cnt_q <= {1'b0, i_delay} + 5'h01;
    end else if (tx_cnt_q != 5'h00) begin
      tx_cnt_q <= tx_cnt_q - 5'h01;
      o_tx_done <= (tx_cnt_q == 5'h01) && !i_fail;
      o_tx_error <= (tx_cnt_q == 5'h01) && i_fail;
    end
  end
  // protocol reset completes after the same delay
  always_ff @(posedge i_clk_sys) begin
    o_proto_reset_done <= 1'b0;
    if (i_srst) begin
      rst_cnt_q <= 5'h00;
    end else if (i_proto_reset_req) begin
      rst_cnt_q <= {1'b0, i_delay} + 5'h01;
    end else if (rst_cnt_q != 5'h00) begin
      rst_cnt_q <= rst_cnt_q - 5'h01;
      o_proto_reset_done <= (rst_cnt_q == 5'h01);
    end
  end
endmodule
`default_nettype wire

// ### verif/pd_soft_reset_checker.sv
// port assertions for the link restart engine
`timescale 1ns/1ps
`default_nettype none
module pd_soft_reset_checker
  import pd_soft_reset_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire pd_msg_t i_rx,
  input wire logic i_rx_unsupported,
  input wire logic i_protocol_error,
  input wire logic i_retries_failed,
  input wire pd_context_t i_ctx,
  input wire logic i_policy_query_offer,
  input wire logic i_exit_ack,
  input wire pd_msg_t o_tx,
  input wire logic o_policy_caps_req,
  input wire logic o_proto_reset_req,
  input wire logic o_handle_in_idle,
  input wire logic o_idle,
  input wire pe_exit_t o_exit,
  input wire logic o_exit_valid
);
  logic hold_q;
  logic held;
  logic calm;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_exit_ack) begin
      hold_q <= 1'b0;
    end else if (o_exit_valid) begin
      hold_q <= 1'b1;
    end
  end
  assign held = hold_q || o_exit_valid;
  assign calm = o_idle && !i_protocol_error && !i_retries_failed;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  a_restart_answer: assert property (!held && i_rx.valid &&
    i_rx.msg_type == 4'hD |=> o_proto_reset_req) else $error("no reset");
  a_restart_start: assert property (o_idle && !i_rx.valid &&
    i_ctx[3:0] == 4'h0 && (i_retries_failed || i_protocol_error &&
    i_ctx.noninterruptible && i_ctx.first_sent) |=> o_proto_reset_req)
    else $error("restart not started");
  a_error_to_idle: assert property (o_idle && !i_rx.valid &&
    !i_retries_failed && i_protocol_error &&
    !(i_ctx.noninterruptible && i_ctx.first_sent) |=> o_handle_in_idle)
    else $error("error not handled in idle");
  a_caps_fetch: assert property (calm && i_rx.valid &&
    !i_rx_unsupported && i_rx.msg_type == 4'h8 |=> o_policy_caps_req)
    else $error("no caps fetch");
  a_query_send: assert property (calm && !i_rx.valid &&
    i_policy_query_offer |-> ##[1:3] o_tx.valid && o_tx.msg_type == 4'h7)
    else $error("no offer query");
  a_unsupp_reply: assert property (calm && i_rx.valid &&
    i_rx_unsupported && i_rx.msg_type != 4'hD |-> ##[1:3]
    o_tx.valid && o_tx.msg_type == 4'h0) else $error("no refusal sent");
  a_exit_pulse: assert property (o_exit_valid |=>
    !o_exit_valid && $stable(o_exit)) else $error("exit not a pulse");
  a_exit_onehot: assert property (o_exit_valid |->
    $onehot(o_exit) && o_exit != EX_NONE) else $error("bad exit code");
  c_full_reset: cover property (o_exit_valid && o_exit == EX_FULL_RESET);
  c_wait_offer: cover property (o_exit_valid && o_exit == EX_WAIT_OFFER);
  c_idle_handle: cover property (o_handle_in_idle);
endmodule
bind pd_soft_reset_engine pd_soft_reset_checker pd_soft_reset_checker_inst (.*);
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the link restart engine, consumer side
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pd_soft_reset_pkg::*;
  logic i_clk_sys, i_srst, unsup, tx_done, tx_err, perr, rfail, query;
  logic caps_ok, prst_done, ack, fail, caps_req, prst_req, in_idle, idle;
  logic exv;
  logic [3:0] dly;
  pd_msg_t rx, tx;
  pd_context_t ctx;
  pe_exit_t ex;
  int mismatches, n_checks;
  pd_soft_reset_engine #(.IS_PROVIDER(1'b0), .RSP_CYCLES(20))
  pd_soft_reset_engine_inst (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_rx(rx), .i_rx_unsupported(unsup), .i_tx_done(tx_done),
    .i_tx_error(tx_err), .i_protocol_error(perr), .i_retries_failed(rfail),
    .i_send_caps_no_ack(1'b0), .i_ctx(ctx), .i_policy_query_offer(query),
    .i_policy_caps_valid(caps_ok), .i_proto_reset_done(prst_done),
    .i_exit_ack(ack), .o_tx(tx), .o_policy_caps_req(caps_req),
    .o_proto_reset_req(prst_req), .o_handle_in_idle(in_idle),
    .o_idle(idle), .o_exit(ex), .o_exit_valid(exv));
  pd_proto_model pd_proto_model_inst (.i_clk_sys(i_clk_sys),
    .i_srst(i_srst), .i_tx(tx), .i_proto_reset_req(prst_req),
    .i_fail(fail), .i_delay(dly), .o_tx_done(tx_done), .o_tx_error(tx_err),
    .o_proto_reset_done(prst_done));
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic step;
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask
  task automatic put_rx(input logic [3:0] m, input logic u);
    rx = '{1'b1, m};
    unsup = u;
    step();
    rx = '0;
    unsup = 1'b0;
  endtask
  task automatic wait_tx(input logic [3:0] m);
    int n;
    n = 0;
    while (!tx.valid && n < 60) begin
      step();
      n++;
    end
    chk("tx message", {3'h0, 1'b1, m}, {3'h0, tx});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (idle !== 1'b1 && n < 60) begin
      step();
      n++;
    end
    chk("idle", 8'h01, {7'h0, idle});
  endtask
  task automatic wait_exit(input pe_exit_t e);
    int n;
    n = 0;
    while (exv !== 1'b1 && n < 60) begin
      step();
      n++;
    end
    chk("exit", {2'b10, e}, {exv, 1'b0, ex});
    step();
    pulse(ack);
    step();
  endtask
  task automatic t_own_caps;
    put_rx(4'h8, 1'b0);
    chk("caps request", 8'h01, {7'h0, caps_req});
    step();
    pulse(caps_ok);
    wait_tx(4'h4);
    wait_idle();
  endtask
  task automatic t_query;
    pulse(query);
    wait_tx(4'h7);
    wait_idle();
  endtask
  task automatic t_unsup;
    put_rx(4'hA, 1'b1);
    wait_tx(4'h0);
    wait_idle();
  endtask
  task automatic t_to_idle(input pd_context_t c);
    ctx = c;
    pulse(perr);
    chk("handled in idle", 8'h01, {7'h0, in_idle});
    ctx = '0;
  endtask
  task automatic t_restart(input int mode, input pe_exit_t e);
    ctx = 8'hC0;
    fail = (mode == 2);
    pulse(perr);
    chk("reset request", 8'h01, {7'h0, prst_req});
    wait_tx(4'hD);
    while (mode == 0 && !tx_done) step();
    if (mode == 0) put_rx(4'h3, 1'b0);
    wait_exit(e);
    fail = 1'b0;
    ctx = '0;
  endtask
  task automatic t_answer(input logic f, input pe_exit_t e);
    fail = f;
    put_rx(4'hD, 1'b0);
    chk("reset request", 8'h01, {7'h0, prst_req});
    wait_tx(4'h3);
    wait_exit(e);
    fail = 1'b0;
  endtask
  task automatic t_fault(input pd_context_t c, input pe_exit_t e);
    ctx = c;
    pulse(rfail);
    wait_exit(e);
    ctx = '0;
  endtask
  initial begin
    {i_srst, unsup, perr, rfail, query, caps_ok, ack, fail} = 8'h80;
    rx = '0;
    ctx = '0;
    dly = 4'h0;
    repeat (3) @(posedge i_clk_sys);
    #1 i_srst = 1'b0;
    step();
    t_own_caps();
    t_query();
    t_unsup();
    t_to_idle(8'h40);
    t_to_idle(8'h80);
    t_restart(0, EX_WAIT_OFFER);
    dly = 4'h5;
    t_restart(1, EX_FULL_RESET);
    t_restart(2, EX_FULL_RESET);
    t_answer(1'b0, EX_WAIT_OFFER);
    t_answer(1'b1, EX_FULL_RESET);
    t_fault(8'h08, EX_FULL_RESET);
    t_fault(8'h04, EX_FULL_RESET);
    t_fault(8'h01, EX_ERROR_RECOVERY);
    $display("all scenarios ended");
    test_done();
  end
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
